// [verilog/csm_core_ctrl.sv]
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "csm_map.svh"
module csm_core_ctrl #(
  parameter logic [31:0] VEC_BASE = 32'h0
) (
  // clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        CE,
  // software register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // pipeline register port
  input  wire logic        CREG_RD,
  input  wire logic [3:0]  CREG_RIDX,
  output logic      [31:0] CREG_RDATA,
  output logic             CREG_ERR,
  input  wire logic        CREG_WR,
  input  wire logic [3:0]  CREG_WIDX,
  input  wire logic [31:0] CREG_WDATA,
  // branches and status instructions
  input  wire logic        BRANCH_WITH_LINK_INSTR,
  input  wire logic        BRANCH_EXCHANGE_INSTR,
  input  wire logic        BRANCH_LINK_EXCHANGE_INSTR,
  input  wire logic        BRANCH_TO_BYTECODE_INSTR,
  input  wire logic        PC_LOAD,
  input  wire logic [31:0] TARGET_ADDR,
  input  wire logic [31:0] LINK_ADDR,
  input  wire logic        STATUS_WRITE_INSTR,
  input  wire logic [31:0] STATUS_WDATA,
  // flags and conditions
  input  wire logic        FLAG_WE,
  input  wire logic [3:0]  FLAG_NZCV,
  input  wire logic        SAT_SET,
  input  wire logic [3:0]  COND,
  output logic             COND_PASS,
  // exceptions
  input  wire logic [7:0]  EXC_REQ,
  input  wire logic [31:0] EXC_LR,
  input  wire logic        EXC_RETURN,
  output logic             VEC_TAKE,
  output logic      [31:0] VEC_ADDR,
  // data access check
  input  wire logic        DATA_REQ,
  input  wire logic [1:0]  DATA_ADDR,
  input  wire logic [1:0]  DATA_SIZE,
  output logic             ALIGN_ERR,
  // hazard check
  input  wire logic [3:0]  HZ_SRC_A,
  input  wire logic [3:0]  HZ_SRC_B,
  input  wire logic [3:0]  EX_DST,
  input  wire logic        EX_VALID,
  input  wire logic        EX_LOAD,
  input  wire logic [3:0]  MEM_DST,
  input  wire logic        MEM_VALID,
  output logic      [1:0]  FWD_A,
  output logic      [1:0]  FWD_B,
  output logic             STALL,
  // state view
  output logic      [2:0]  EXEC_STATE,
  output logic      [2:0]  PIPE_DEPTH,
  output logic      [1:0]  DECODE_CYCLES,
  output logic      [1:0]  FETCH_SIZE,
  output logic      [4:0]  CUR_MODE,
  output logic             PRIVILEGED
);
  csm_pkg::csm_core_s s;
  csm_pkg::csm_core_s next_s;
  csm_pkg::csm_ist_e  ist;
  logic               x_take;
  logic [2:0]         x_code;
  logic [31:0]        saved_status_word_cur;

  // physical slot of a logical register in a given mode
  function automatic logic [4:0] phys(input logic [3:0] r,
                                      input logic [4:0] m);
    phys = {1'b0, r};
    if (m == `CSM_MODE_FIQ && r >= 4'h8 && r <= 4'he) begin
      phys = 5'(`CSM_PB_FIQ + r - 4'h8);
    end else if (r == 4'hd || r == 4'he) begin
      case (m)
        `CSM_MODE_SVC: phys = 5'(`CSM_PB_SVC + r - 4'hd);
        `CSM_MODE_ABT: phys = 5'(`CSM_PB_ABT + r - 4'hd);
        `CSM_MODE_UND: phys = 5'(`CSM_PB_UND + r - 4'hd);
        `CSM_MODE_IRQ: phys = 5'(`CSM_PB_IRQ + r - 4'hd);
        default:       phys = {1'b0, r};
      endcase
    end
  endfunction

  // saved status slot; 7 means the mode has none
  function automatic logic [2:0] sslot(input logic [4:0] m);
    case (m)
      `CSM_MODE_FIQ: sslot = 3'h0;
      `CSM_MODE_IRQ: sslot = 3'h1;
      `CSM_MODE_SVC: sslot = 3'h2;
      `CSM_MODE_ABT: sslot = 3'h3;
      `CSM_MODE_UND: sslot = 3'h4;
      default:       sslot = 3'h7;
    endcase
  endfunction

  function automatic logic valid_mode(input logic [4:0] m);
    valid_mode = m == `CSM_MODE_USR || m == `CSM_MODE_SYS ||
                 sslot(m) != 3'h7;
  endfunction

  // status write: flags always, I/F bits and mode only when privileged;
  // an unknown mode code is ignored so the bank map stays sane
  function automatic logic [31:0] swrite(input logic [31:0] c,
                                         input logic [31:0] d);
    swrite = c;
    swrite[31:27] = d[31:27];
    if (c[4:0] != `CSM_MODE_USR) begin
      swrite[`CSM_B_I] = d[`CSM_B_I];
      swrite[`CSM_B_F] = d[`CSM_B_F];
      if (valid_mode(d[4:0])) begin
        swrite[4:0] = d[4:0];
      end
    end
  endfunction

  always_comb begin
    if (s.current_status_word[`CSM_B_J]) begin
      ist = csm_pkg::CSM_ST_BC;
    end else if (s.current_status_word[`CSM_B_T]) begin
      ist = csm_pkg::CSM_ST_T16;
    end else begin
      ist = csm_pkg::CSM_ST_A32;
    end
  end

  always_comb begin
    saved_status_word_cur = 32'h0;
    if (sslot(s.current_status_word[4:0]) != 3'h7) begin
      saved_status_word_cur = s.saved_status_word[sslot(s.current_status_word[4:0])];
    end
  end

  csm_exc_prio u_prio (
    .clk     (MCLK),
    .rst     (SRST),
    .req     (EXC_REQ),
    .irq_off (s.current_status_word[`CSM_B_I]),
    .fiq_off (s.current_status_word[`CSM_B_F]),
    .take    (x_take),
    .code    (x_code)
  );

  csm_hazard u_hz (
    .clk       (MCLK),
    .rst       (SRST),
    .src_a     (HZ_SRC_A),
    .src_b     (HZ_SRC_B),
    .ex_dst    (EX_DST),
    .ex_valid  (EX_VALID),
    .ex_load   (EX_LOAD),
    .mem_dst   (MEM_DST),
    .mem_valid (MEM_VALID),
    .fwd_a     (FWD_A),
    .fwd_b     (FWD_B),
    .stall     (STALL)
  );

  always_comb begin
    logic [4:0]  m;
    logic [4:0]  nm;
    logic [31:0] voff;
    logic        bx;
    m    = s.current_status_word[4:0];
    nm   = m;
    voff = 32'h0;
    bx   = 1'b0;
    next_s = s;
    if (CE) begin
      next_s.rdata = 32'h0;
      next_s.vtake = 1'b0;
      next_s.aerr  = 1'b0;
      next_s.cerr  = 1'b0;
      // pipeline register traffic
      if (CREG_RD) begin
        next_s.cdata = s.gpr[phys(CREG_RIDX, m)];
        next_s.cerr  = s.current_status_word[`CSM_B_T] && !s.current_status_word[`CSM_B_J] &&
                       CREG_RIDX >= 4'h8 && CREG_RIDX <= 4'hc;
      end
      if (CREG_WR) begin
        next_s.gpr[phys(CREG_WIDX, m)] = CREG_WDATA;
      end
      if (DATA_REQ) begin
        next_s.aerr = (DATA_SIZE == `CSM_SZ_WORD && DATA_ADDR != 2'h0) ||
                      (DATA_SIZE == `CSM_SZ_HALF && DATA_ADDR[0]) ||
                      DATA_SIZE == 2'h3;
      end
      if (FLAG_WE) begin
        next_s.current_status_word[31:28] = FLAG_NZCV;
      end
      // software register port
      if (REG_WR) begin
        if (REG_ADDR == `CSM_OFS_CURRENT_STATUS_WORD) begin
          next_s.current_status_word = swrite(next_s.current_status_word, REG_WDATA);
        end else if (REG_ADDR == `CSM_OFS_SAVED_STATUS_WORD) begin
          if (sslot(m) != 3'h7) begin
            next_s.saved_status_word[sslot(m)] = REG_WDATA;
          end
        end else if (REG_ADDR == `CSM_OFS_BIDX) begin
          next_s.bidx = REG_WDATA[4:0];
        end else if (REG_ADDR == `CSM_OFS_BDATA) begin
          if (s.bidx < 5'(`CSM_NGPR)) begin
            next_s.gpr[s.bidx] = REG_WDATA;
          end
        end
      end
      if (REG_RD) begin
        if (REG_ADDR == `CSM_OFS_CURRENT_STATUS_WORD) begin
          next_s.rdata = s.current_status_word;
        end else if (REG_ADDR == `CSM_OFS_SAVED_STATUS_WORD) begin
          next_s.rdata = saved_status_word_cur;
        end else if (REG_ADDR == `CSM_OFS_BIDX) begin
          next_s.rdata = {27'h0, s.bidx};
        end else if (REG_ADDR == `CSM_OFS_BDATA) begin
          if (s.bidx < 5'(`CSM_NGPR)) begin
            next_s.rdata = s.gpr[s.bidx];
          end
        end else if (REG_ADDR == `CSM_OFS_STATE) begin
          next_s.rdata = {24'h0, PIPE_DEPTH, ist, FETCH_SIZE};
        end
      end
      if (STATUS_WRITE_INSTR) begin
        next_s.current_status_word = swrite(next_s.current_status_word, STATUS_WDATA);
      end
      // a saturation event beats a same-cycle status write, but not a same-cycle exception return
      if (SAT_SET) begin
        next_s.current_status_word[`CSM_B_Q] = 1'b1;
      end
      // state switching
      if (BRANCH_WITH_LINK_INSTR || BRANCH_LINK_EXCHANGE_INSTR) begin
        next_s.gpr[phys(4'he, m)] = LINK_ADDR;
      end
      bx = BRANCH_EXCHANGE_INSTR || BRANCH_LINK_EXCHANGE_INSTR || PC_LOAD;
      if (bx && !s.current_status_word[`CSM_B_J]) begin
        next_s.current_status_word[`CSM_B_T] = TARGET_ADDR[0];
      end else if (BRANCH_TO_BYTECODE_INSTR) begin
        next_s.current_status_word[`CSM_B_J] = !s.current_status_word[`CSM_B_J] && !s.current_status_word[`CSM_B_T];
      end
      // return: saved word brings back mode and 16-bit/bytecode state
      if (EXC_RETURN && sslot(m) != 3'h7) begin
        next_s.current_status_word = saved_status_word_cur;
      end
      // entry; bytecode is restartable, so no partial state is kept
      if (x_take) begin
        case (x_code)
          3'(`CSM_X_RST): begin
            nm = `CSM_MODE_SVC;
            voff = `CSM_VO_RST;
          end
          3'(`CSM_X_DABT): begin
            nm = `CSM_MODE_ABT;
            voff = `CSM_VO_DABT;
          end
          3'(`CSM_X_FIQ): begin
            nm = `CSM_MODE_FIQ;
            voff = `CSM_VO_FIQ;
          end
          3'(`CSM_X_IRQ): begin
            nm = `CSM_MODE_IRQ;
            voff = `CSM_VO_IRQ;
          end
          3'(`CSM_X_UND): begin
            nm = `CSM_MODE_UND;
            voff = `CSM_VO_UND;
          end
          3'(`CSM_X_SWI): begin
            nm = `CSM_MODE_SVC;
            voff = `CSM_VO_SWI;
          end
          default: begin
            nm = `CSM_MODE_ABT;
            voff = `CSM_VO_PABT;
          end
        endcase
        next_s.gpr[phys(4'he, nm)] = EXC_LR;
        next_s.saved_status_word[sslot(nm)] = s.current_status_word;
        next_s.current_status_word = s.current_status_word;
        next_s.current_status_word[4:0] = nm;
        next_s.current_status_word[`CSM_B_J] = 1'b0;
        next_s.current_status_word[`CSM_B_T] = 1'b0;
        next_s.current_status_word[`CSM_B_I] = 1'b1;
        if (nm == `CSM_MODE_FIQ || x_code == 3'(`CSM_X_RST)) begin
          next_s.current_status_word[`CSM_B_F] = 1'b1;
        end
        next_s.vec   = VEC_BASE + voff;
        next_s.vtake = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      s <= '0;
      s.current_status_word <= `CSM_CURRENT_STATUS_WORD_RST;
    end else begin
      s <= next_s;
    end
  end

  // condition check never looks at the saturation flag
  always_comb begin
    logic n;
    logic z;
    logic c;
    logic v;
    logic p;
    p = 1'b0;
    {n, z, c, v} = s.current_status_word[31:28];
    case (COND[3:1])
      3'h0: p = z;
      3'h1: p = c;
      3'h2: p = n;
      3'h3: p = v;
      3'h4: p = c && !z;
      3'h5: p = n == v;
      3'h6: p = !z && n == v;
      default: p = 1'b1;
    endcase
    COND_PASS = COND == 4'hf ? 1'b0 : (COND[0] && COND != 4'he) ^ p;
  end

  always_comb begin
    EXEC_STATE = ist;
    PIPE_DEPTH = s.current_status_word[`CSM_B_J] ? `CSM_DEPTH_BC : `CSM_DEPTH_STD;
    DECODE_CYCLES = s.current_status_word[`CSM_B_J] ? 2'h2 : 2'h1;
    FETCH_SIZE = ist == csm_pkg::CSM_ST_T16 ? `CSM_SZ_HALF
                                             : `CSM_SZ_WORD;
    CUR_MODE   = s.current_status_word[4:0];
    PRIVILEGED = s.current_status_word[4:0] != `CSM_MODE_USR;
    REG_RDATA  = s.rdata;
    CREG_RDATA = s.cdata;
    CREG_ERR   = s.cerr;
    VEC_TAKE   = s.vtake;
    VEC_ADDR   = s.vec;
    ALIGN_ERR  = s.aerr;
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);

  bc_word_fetch_a: assert property (
    s.current_status_word[`CSM_B_J] |-> FETCH_SIZE == `CSM_SZ_WORD)
    else $error("bytecode fetch not a word");
  depth_a: assert property (
    PIPE_DEPTH == (ist == csm_pkg::CSM_ST_BC ? 3'h6 : 3'h5))
    else $error("pipeline depth wrong for state");
  exc_in_a32_a: assert property (
    VEC_TAKE |-> EXEC_STATE == csm_pkg::CSM_ST_A32 && PRIVILEGED)
    else $error("handler not in 32-bit privileged state");
  exc_ret_a: assert property (
    CE && EXC_RETURN && !x_take && sslot(CUR_MODE) != 3'h7
    |=> s.current_status_word == $past(saved_status_word_cur))
    else $error("return did not restore status");
  saved_status_word_save_a: assert property (
    CE && x_take |=> saved_status_word_cur == $past(s.current_status_word) && VEC_TAKE)
    else $error("status not saved on entry");
  q_sticky_a: assert property (
    CE && s.current_status_word[`CSM_B_Q] && !STATUS_WRITE_INSTR && !x_take &&
    !EXC_RETURN && !(REG_WR && REG_ADDR == `CSM_OFS_CURRENT_STATUS_WORD)
    |=> s.current_status_word[`CSM_B_Q])
    else $error("saturation flag dropped");
  align_a: assert property (
    CE && DATA_REQ && DATA_SIZE == `CSM_SZ_WORD && DATA_ADDR[0]
    |=> ALIGN_ERR ##1 !ALIGN_ERR || $past(DATA_REQ || !CE))
    else $error("misaligned word not flagged");
  t16_regs_a: assert property (
    CE && CREG_RD && EXEC_STATE == csm_pkg::CSM_ST_T16 &&
    CREG_RIDX == 4'ha |=> CREG_ERR)
    else $error("high register reached in 16-bit state");
endmodule
`default_nettype wire

// [verilog/csm_map.svh]
// Overview of operation
// - three states: 32-bit, 16-bit, bytecode
// - bytecode state always fetches full words
// - exchange branches and pc loads switch state, except in bytecode
// - exceptions run in the 32-bit state
// - exception return restores the saved state
// - 32/16-bit states use five pipeline stages
// - bytecode state uses six stages, two-cycle decode
// - byte, halfword, word accesses, natural alignment
// - register hazards stall or forward automatically
// - interrupt in bytecode switches to 32-bit state
// - seven modes; all but user privileged
// - 31 general and 6 status registers
// - fast interrupt banks r8-r14, others r13-r14
// - link writes banked r14; r15 is pc
// - privileged modes other than system see a saved status word
// - one current and five saved status words
// - saturation flag sticky until status write or exception return
// - conditions test only N, Z, C, V
// - four ALU flags from last flag-setting op
// - bytecode bit set in bytecode; else 16-bit bit
// - five-bit mode field and interrupt disables
// - 16-bit state: r0-r7, sp, lr, pc only
// - fixed priority among simultaneous exceptions
// - entry saves lr, status, forces mode, vectors
`ifndef CSM_MAP_SVH
`define CSM_MAP_SVH
`define CSM_MODE_USR 5'h10
`define CSM_MODE_FIQ 5'h11
`define CSM_MODE_IRQ 5'h12
`define CSM_MODE_SVC 5'h13
`define CSM_MODE_ABT 5'h17
`define CSM_MODE_UND 5'h1b
`define CSM_MODE_SYS 5'h1f
`define CSM_B_N 31
`define CSM_B_Z 30
`define CSM_B_C 29
`define CSM_B_V 28
`define CSM_B_Q 27
`define CSM_B_J 24
`define CSM_B_I 7
`define CSM_B_F 6
`define CSM_B_T 5
`define CSM_CURRENT_STATUS_WORD_RST 32'h000000d3
`define CSM_PB_FIQ 5'h10
`define CSM_PB_SVC 5'h17
`define CSM_PB_ABT 5'h19
`define CSM_PB_UND 5'h1b
`define CSM_PB_IRQ 5'h1d
`define CSM_NGPR 31
`define CSM_X_RST 0
`define CSM_X_DABT 1
`define CSM_X_FIQ 2
`define CSM_X_IRQ 3
`define CSM_X_PABT 4
`define CSM_X_BKPT 5
`define CSM_X_UND 6
`define CSM_X_SWI 7
`define CSM_VO_RST 32'h00
`define CSM_VO_UND 32'h04
`define CSM_VO_SWI 32'h08
`define CSM_VO_PABT 32'h0c
`define CSM_VO_DABT 32'h10
`define CSM_VO_IRQ 32'h18
`define CSM_VO_FIQ 32'h1c
`define CSM_OFS_CURRENT_STATUS_WORD 8'h00
`define CSM_OFS_SAVED_STATUS_WORD 8'h04
`define CSM_OFS_BIDX 8'h08
`define CSM_OFS_BDATA 8'h0c
`define CSM_OFS_STATE 8'h10
`define CSM_DEPTH_STD 3'h5
`define CSM_DEPTH_BC 3'h6
`define CSM_SZ_BYTE 2'h0
`define CSM_SZ_HALF 2'h1
`define CSM_SZ_WORD 2'h2
`define CSM_FWD_NONE 2'h0
`define CSM_FWD_EX 2'h1
`define CSM_FWD_MEM 2'h2
`endif

// [verilog/csm_pkg.sv]
`default_nettype none
`include "csm_map.svh"
package csm_pkg;
  typedef enum logic [2:0] {
    CSM_ST_A32 = 3'b001,
    CSM_ST_T16 = 3'b010,
    CSM_ST_BC  = 3'b100
  } csm_ist_e;
  typedef struct packed {
    logic [`CSM_NGPR-1:0][31:0] gpr;
    logic [31:0]                current_status_word;
    logic [4:0][31:0]           saved_status_word;
    logic [4:0]                 bidx;
    logic [31:0]                rdata;
    logic [31:0]                cdata;
    logic                       cerr;
    logic [31:0]                vec;
    logic                       vtake;
    logic                       aerr;
  } csm_core_s;
endpackage
`default_nettype wire

// [verilog/csm_hazard.sv]
`timescale 1ns/100ps
`default_nettype none
`include "csm_map.svh"
module csm_hazard (
  // clock for checks
  input  wire logic       clk,
  input  wire logic       rst,
  // operands and in-flight destinations
  input  wire logic [3:0] src_a,
  input  wire logic [3:0] src_b,
  input  wire logic [3:0] ex_dst,
  input  wire logic       ex_valid,
  input  wire logic       ex_load,
  input  wire logic [3:0] mem_dst,
  input  wire logic       mem_valid,
  // result
  output logic      [1:0] fwd_a,
  output logic      [1:0] fwd_b,
  output logic            stall
);
  function automatic logic [1:0] pick(input logic [3:0] r);
    pick = `CSM_FWD_NONE;
    if (ex_valid && ex_dst == r) begin
      pick = `CSM_FWD_EX;
    end else if (mem_valid && mem_dst == r) begin
      pick = `CSM_FWD_MEM;
    end
  endfunction
  // load data exists only after memory stage, so ex match must stall
  always_comb begin
    fwd_a = pick(src_a);
    fwd_b = pick(src_b);
    stall = ex_valid && ex_load && (ex_dst == src_a || ex_dst == src_b);
  end
  load_use_a: assert property (@(posedge clk) disable iff (rst)
    ex_valid && ex_load && ex_dst == src_a |-> stall)
    else $error("load-use hazard not stalled");
  fwd_ex_a: assert property (@(posedge clk) disable iff (rst)
    ex_valid && ex_dst == src_a |-> fwd_a == `CSM_FWD_EX)
    else $error("execute result not forwarded");
endmodule
`default_nettype wire

// [verilog/csm_exc_prio.sv]
`timescale 1ns/100ps
`default_nettype none
`include "csm_map.svh"
module csm_exc_prio (
  // clock for checks
  input  wire logic       clk,
  input  wire logic       rst,
  // requests and disables
  input  wire logic [7:0] req,
  input  wire logic       irq_off,
  input  wire logic       fiq_off,
  // winner
  output logic            take,
  output logic      [2:0] code
);
  logic [7:0] live;
  always_comb begin
    live = req;
    live[`CSM_X_IRQ] = req[`CSM_X_IRQ] && !irq_off;
    live[`CSM_X_FIQ] = req[`CSM_X_FIQ] && !fiq_off;
    take = |live;
    code = 3'h0;
    // lowest index wins: reset, data abort, fiq, irq, prefetch, rest
    for (int i = 7; i >= 0; i--) begin
      if (live[i]) begin
        code = 3'(i);
      end
    end
  end
  dabt_over_fiq_a: assert property (@(posedge clk) disable iff (rst)
    req[`CSM_X_DABT] && !req[`CSM_X_RST] |-> code == 3'(`CSM_X_DABT))
    else $error("data abort lost priority");
endmodule
`default_nettype wire

// [verification/csm_mem_side.sv]
`timescale 1ns/100ps
`default_nettype none
module csm_mem_side (
  // clock and command from the bench
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [1:0] addr_in,
  input  wire logic [1:0] size_in,
  // data request toward the core
  output logic            req,
  output logic      [1:0] addr,
  output logic      [1:0] size
);
  // released lines flip so a stale value never looks valid
  always_ff @(posedge clk) begin
    req <= start;
    if (start) begin
      addr <= addr_in;
      size <= size_in;
    end else if (req) begin
      addr <= ~addr;
      size <= ~size;
    end
  end
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "csm_map.svh"
module testbench;
  localparam logic [31:0] VB = 32'h00000100;
  logic mclk, srst, ce, reg_wr, reg_rd, creg_rd, creg_wr, creg_err;
  logic bl, bx, branch_link_exchange_instr, branch_to_bytecode_instr, pcl, sw, few, sat, eret, cpass, vtake;
  logic aerr, stall, priv, exv, exl, memv, mstart, dreq;
  logic [7:0] reg_addr, exc;
  logic [31:0] reg_wdata, reg_rdata, creg_rdata, creg_wdata;
  logic [31:0] tgt, lnk, swd, elr, vaddr, d;
  logic [3:0] ridx, widx, nzcv, cond, hsa, hsb, exd, memd;
  logic [1:0] fa, fb, fsz, dcyc, maddr, msize, daddr, dsize;
  logic [2:0] est, pdep;
  logic [4:0] mode;
  int err_count, check_count;

  csm_core_ctrl #(.VEC_BASE(VB)) dut_u (
    .MCLK(mclk), .SRST(srst), .CE(ce), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .CREG_RD(creg_rd), .CREG_RIDX(ridx),
    .CREG_RDATA(creg_rdata), .CREG_ERR(creg_err), .CREG_WR(creg_wr),
    .CREG_WIDX(widx), .CREG_WDATA(creg_wdata),
    .BRANCH_WITH_LINK_INSTR(bl), .BRANCH_EXCHANGE_INSTR(bx),
    .BRANCH_LINK_EXCHANGE_INSTR(branch_link_exchange_instr), .BRANCH_TO_BYTECODE_INSTR(branch_to_bytecode_instr),
    .PC_LOAD(pcl), .TARGET_ADDR(tgt), .LINK_ADDR(lnk),
    .STATUS_WRITE_INSTR(sw), .STATUS_WDATA(swd), .FLAG_WE(few),
    .FLAG_NZCV(nzcv), .SAT_SET(sat), .COND(cond), .COND_PASS(cpass),
    .EXC_REQ(exc), .EXC_LR(elr), .EXC_RETURN(eret), .VEC_TAKE(vtake),
    .VEC_ADDR(vaddr), .DATA_REQ(dreq), .DATA_ADDR(daddr),
    .DATA_SIZE(dsize), .ALIGN_ERR(aerr), .HZ_SRC_A(hsa), .HZ_SRC_B(hsb),
    .EX_DST(exd), .EX_VALID(exv), .EX_LOAD(exl), .MEM_DST(memd),
    .MEM_VALID(memv), .FWD_A(fa), .FWD_B(fb), .STALL(stall),
    .EXEC_STATE(est), .PIPE_DEPTH(pdep), .DECODE_CYCLES(dcyc),
    .FETCH_SIZE(fsz), .CUR_MODE(mode), .PRIVILEGED(priv));

  csm_mem_side mem_u (.clk(mclk), .start(mstart), .addr_in(maddr),
    .size_in(msize), .req(dreq), .addr(daddr), .size(dsize));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // strobes last exactly one cycle; sample after the edge settles
  task automatic cyc();
    @(posedge mclk);
    {reg_wr, reg_rd, creg_rd, creg_wr, bl, bx, branch_link_exchange_instr, branch_to_bytecode_instr} <= '0;
    {pcl, sw, few, sat, eret, mstart} <= '0;
    exc <= 8'h00;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    cyc();
    d = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    cyc();
  endtask
  task automatic stw(input logic [31:0] v);
    @(posedge mclk);
    sw <= 1'b1;
    swd <= v;
    cyc();
  endtask
  task automatic crd(input logic [3:0] i);
    @(posedge mclk);
    creg_rd <= 1'b1;
    ridx <= i;
    cyc();
    d = creg_rdata;
  endtask
  task automatic cwr(input logic [3:0] i, input logic [31:0] v);
    @(posedge mclk);
    creg_wr <= 1'b1;
    widx <= i;
    creg_wdata <= v;
    cyc();
  endtask
  task automatic exc_go(input logic [7:0] r);
    @(posedge mclk);
    exc <= r;
    elr <= {24'h0, r};
    cyc();
  endtask
  function automatic logic cx(input logic [3:0] c, input logic [3:0] f);
    logic n, z, k, v;
    {n, z, k, v} = f;
    case (c)
      0: return z;  1: return !z;  2: return k;  3: return !k;
      4: return n;  5: return !n;  6: return v;  7: return !v;
      8: return k && !z;  9: return !k || z;
      10: return n == v;  11: return n != v;
      12: return !z && n == v;  13: return z || n != v;
      14: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task automatic t_reset();
    rd(8'h00);
    chk(d, `CSM_CURRENT_STATUS_WORD_RST);
    cyc();
    chk(reg_rdata, 32'h0);
    chk(mode, `CSM_MODE_SVC);
    chk(priv, 1'b1);
    chk(est, 3'b001);
    chk(pdep, `CSM_DEPTH_STD);
    chk(dcyc, 2'h1);
    rd(8'h10);
    chk(d, 32'ha6);
    rd(8'h20);
    chk(d, 32'h0);
  endtask
  task automatic t_state();
    @(posedge mclk);
    bx <= 1'b1;
    tgt <= 32'h1;
    cyc();
    chk(est, 3'b010);
    chk(fsz, `CSM_SZ_HALF);
    chk(pdep, `CSM_DEPTH_STD);
    crd(4'h8);
    chk(creg_err, 1'b1);
    crd(4'h7);
    chk(creg_err, 1'b0);
    @(posedge mclk);
    branch_to_bytecode_instr <= 1'b1;
    cyc();
    chk(est, 3'b010);
    @(posedge mclk);
    pcl <= 1'b1;
    tgt <= 32'h0;
    cyc();
    chk(est, 3'b001);
    @(posedge mclk);
    branch_to_bytecode_instr <= 1'b1;
    cyc();
    chk(est, 3'b100);
    chk(pdep, `CSM_DEPTH_BC);
    chk(dcyc, 2'h2);
    chk(fsz, `CSM_SZ_WORD);
    rd(8'h00);
    chk(d[`CSM_B_J], 1'b1);
    stw(32'h13);
    exc_go(8'h08);
    chk(vaddr, VB + `CSM_VO_IRQ);
    chk(est, 3'b001);
    chk(mode, `CSM_MODE_IRQ);
    rd(8'h04);
    chk(d[`CSM_B_J], 1'b1);
    chk(d[4:0], `CSM_MODE_SVC);
    @(posedge mclk);
    eret <= 1'b1;
    cyc();
    chk(est, 3'b100);
    @(posedge mclk);
    branch_to_bytecode_instr <= 1'b1;
    cyc();
    chk(est, 3'b001);
  endtask
  task automatic t_exc();
    logic [31:0] vo [8];
    logic [4:0] md [8];
    vo = '{32'h00, 32'h10, 32'h1c, 32'h18, 32'h0c, 32'h0c, 32'h04, 32'h08};
    md = '{5'h13, 5'h17, 5'h11, 5'h12, 5'h17, 5'h17, 5'h1b, 5'h13};
    for (int i = 0; i < 8; i++) begin
      stw(32'h13);
      exc_go(8'(1 << i));
      chk(vtake, 1'b1);
      chk(vaddr, VB + vo[i]);
      chk(mode, md[i]);
      crd(4'he);
      chk(d, 32'(1 << i));
      chk(vtake, 1'b0);
    end
    stw(32'h13);
    exc_go(8'hfe);
    chk(vaddr, VB + `CSM_VO_DABT);
    stw(32'h13);
    exc_go(8'hf8);
    chk(vaddr, VB + `CSM_VO_IRQ);
    exc_go(8'hf8);
    chk(vaddr, VB + `CSM_VO_PABT);
    stw(32'hd3);
    exc_go(8'h0c);
    chk(vtake, 1'b0);
  endtask
  task automatic t_bank();
    cwr(4'h8, 32'h8);
    cwr(4'hd, 32'hd);
    stw(32'h11);
    crd(4'h8);
    chk(d, 32'h0);
    cwr(4'h8, 32'hf8);
    stw(32'h12);
    crd(4'h8);
    chk(d, 32'h8);
    crd(4'hd);
    chk(d, 32'h0);
    @(posedge mclk);
    bl <= 1'b1;
    lnk <= 32'habc;
    cyc();
    crd(4'he);
    chk(d, 32'habc);
    @(posedge mclk);
    branch_link_exchange_instr <= 1'b1;
    lnk <= 32'h5a;
    tgt <= 32'h1;
    cyc();
    chk(est, 3'b010);
    crd(4'he);
    chk(d, 32'h5a);
    stw(32'h13);
    crd(4'hd);
    chk(d, 32'hd);
    wr(8'h08, 32'd16);
    rd(8'h0c);
    chk(d, 32'hf8);
    wr(8'h08, 32'd30);
    rd(8'h0c);
    chk(d, 32'h5a);
    wr(8'h08, 32'd31);
    rd(8'h0c);
    chk(d, 32'h0);
    stw(32'h1f);
    chk(priv, 1'b1);
    rd(8'h04);
    chk(d, 32'h0);
    stw(32'h10);
    chk(priv, 1'b0);
    stw(32'h13);
    chk(mode, `CSM_MODE_USR);
    exc_go(8'h80);
    chk(mode, `CSM_MODE_SVC);
  endtask
  task automatic t_flags();
    @(posedge mclk);
    few <= 1'b1;
    nzcv <= 4'b0100;
    cyc();
    @(posedge mclk);
    sat <= 1'b1;
    cyc();
    rd(8'h00);
    chk(d[31:27], 5'b01001);
    for (int c = 0; c < 16; c++) begin
      @(posedge mclk);
      cond <= 4'(c);
      #1;
      chk(cpass, cx(4'(c), 4'b0100));
    end
    @(posedge mclk);
    few <= 1'b1;
    nzcv <= 4'b1011;
    cyc();
    rd(8'h00);
    chk(d[31:27], 5'b10111);
    stw(32'hb0000013);
    rd(8'h00);
    chk(d[31:27], 5'b10110);
    @(posedge mclk);
    sat <= 1'b1;
    sw <= 1'b1;
    swd <= 32'hb0000013;
    cyc();
    rd(8'h00);
    chk(d[31:27], 5'b10111);
    @(posedge mclk);
    ce <= 1'b0;
    few <= 1'b1;
    nzcv <= 4'h0;
    cyc();
    @(posedge mclk);
    ce <= 1'b1;
    rd(8'h00);
    chk(d[31:28], 4'b1011);
  endtask
  task automatic t_align();
    for (int s = 0; s < 4; s++) begin
      for (int a = 0; a < 4; a++) begin
        @(posedge mclk);
        mstart <= 1'b1;
        msize <= 2'(s);
        maddr <= 2'(a);
        cyc();
        @(posedge mclk);
        #1;
        chk(aerr, s == 3 || (s == 1 && a % 2 == 1) || (s == 2 && a != 0));
      end
    end
  endtask
  task automatic t_hazard();
    @(posedge mclk);
    {hsa, hsb, exd, memd} <= {4'h3, 4'h5, 4'h3, 4'h5};
    {exv, exl, memv} <= 3'b101;
    #1;
    chk({fa, fb, stall}, 5'b01100);
    @(posedge mclk);
    memd <= 4'h3;
    exl <= 1'b1;
    #1;
    chk({fa, stall}, 3'b011);
    @(posedge mclk);
    exv <= 1'b0;
    #1;
    chk({fa, stall}, 3'b100);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #20000;
    err_count++;
    summarize();
  end
  initial begin
    {srst, ce, reg_wr, reg_rd, creg_rd, creg_wr, bl, bx, branch_link_exchange_instr, branch_to_bytecode_instr} = '0;
    {pcl, sw, few, sat, eret, exv, exl, memv, mstart} = '0;
    {reg_addr, exc, reg_wdata, creg_wdata, tgt, lnk, swd, elr} = '0;
    {ridx, widx, nzcv, cond, hsa, hsb, exd, memd, maddr, msize} = '0;
    srst = 1'b1;
    ce = 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_state();
    t_exc();
    t_bank();
    t_flags();
    t_align();
    t_hazard();
    summarize();
  end
endmodule
`default_nettype wire
